// ==== core/msc_pkg.sv ====
package msc_pkg;
	// Management map
	localparam logic [7:0] DEV_ADDR_LOWER  = 8'ha0;
	localparam logic [7:0] OFS_STATUS      = 8'h02;
	localparam logic [7:0] OFS_FLAG_FIRST  = 8'h03;
	localparam logic [7:0] OFS_FLAG_LAST   = 8'h15;
	localparam logic [7:0] OFS_POWER_CTRL  = 8'h5d;
	localparam logic [7:0] OFS_POWER_CLASS = 8'h81;
	// Field positions
	localparam int BIT_NOT_READY  = 0;
	localparam int BIT_PWR_OVRD   = 0;
	localparam int BIT_PWR_SET    = 1;
	localparam int BIT_CLASS_LSB  = 6;
	// Reset values and class codes
	localparam logic [1:0] PWR_CTRL_RST  = 2'h0;
	localparam logic [2:0] PIN_BIAS_RST  = 3'h7;
	localparam logic [1:0] CLASS_DEFAULT = 2'h0;
	localparam logic [1:0] CLASS_LOW     = 2'h0;
	// Timing
	localparam int CLK_HZ          = 20000000;
	localparam int T_RESET_INIT_NS = 10000;
	localparam int T_INIT_US       = 2000;
	localparam int RESET_MIN_CYC   =
		(T_RESET_INIT_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int INIT_CYC        = T_INIT_US * (CLK_HZ / 1000000);

	typedef enum logic [1:0] {
		ST_INIT  = 2'b00,
		ST_READY = 2'b01,
		ST_HOLD  = 2'b11
	} msc_state_e;

	typedef struct packed {
		logic       we;
		logic [7:0] dev;
		logic [7:0] addr;
		logic [7:0] wdata;
	} msc_req_s;

	typedef struct packed {
		logic       override;
		logic       set;
	} msc_pwr_s;
endpackage : msc_pkg

// ==== core/msc_sideband.sv ====
`timescale 1ns/1ps
`default_nettype none
module msc_sideband #(
	parameter int         INIT_CYCLES = msc_pkg::INIT_CYC,
	parameter logic [1:0] POWER_CLASS = msc_pkg::CLASS_DEFAULT
) (
	input  wire logic            i_sys_clk,
	input  wire logic            i_rst_n,
	input  wire logic            i_module_select_n,
	input  wire logic            i_module_reset_n,
	input  wire logic            i_low_power_request,
	input  wire logic            i_mgmt_valid,
	input  wire msc_pkg::msc_req_s i_mgmt_req,
	output logic                 o_mgmt_enable,
	output logic                 o_mgmt_ack,
	output logic [7:0]           o_mgmt_rdata,
	output logic [2:0]           o_pin_bias_en,
	output logic                 o_attention_n,
	output logic                 o_presence_n,
	output logic                 o_low_power,
	output logic                 o_tx_enable,
	output logic                 o_rx_enable,
	output logic                 o_init_busy
);
	localparam int CNT_W = $clog2(INIT_CYCLES + 1);
	localparam int RST_W = $clog2(msc_pkg::RESET_MIN_CYC + 1);
	localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYCLES - 1);
	localparam logic [RST_W-1:0] RST_MIN   =
		RST_W'(msc_pkg::RESET_MIN_CYC);

	logic [2:0]        pin_s1_q;
	logic [2:0]        pin_s2_q;
	logic              sel_s;
	logic              rst_pin_s;
	logic              lp_pin_s;
	msc_pkg::msc_state_e state_q;
	logic [CNT_W-1:0]  init_cnt_q;
	logic [RST_W-1:0]  low_cnt_q;
	logic              not_ready_q;
	logic              armed_q;
	logic              restart_q;
	logic              seq_busy;
	msc_pkg::msc_pwr_s pwr_q;
	logic              taken;
	logic              lower_page;
	logic              rd_status;
	logic              rd_flag;
	logic              low_power_d;
	logic              restrict_d;
	logic [7:0]        rdata_d;

	// Pin order: select, reset, low-power request
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_s1_q <= msc_pkg::PIN_BIAS_RST;
			pin_s2_q <= msc_pkg::PIN_BIAS_RST;
		end else begin
			pin_s1_q <= {i_module_select_n, i_module_reset_n,
				i_low_power_request};
			pin_s2_q <= pin_s1_q;
		end
	end

	assign sel_s     = ~pin_s2_q[2];
	assign rst_pin_s = pin_s2_q[1];
	assign lp_pin_s  = pin_s2_q[0];

	// Pull-ups are analog; the pad ring takes these enables
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pin_bias_en <= msc_pkg::PIN_BIAS_RST;
			o_presence_n  <= 1'b0;
		end else begin
			o_pin_bias_en <= msc_pkg::PIN_BIAS_RST;
			o_presence_n  <= 1'b0;
		end
	end

	// Reset sequencer; power-up enters init directly
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q    <= msc_pkg::ST_INIT;
			init_cnt_q <= '0;
			low_cnt_q  <= '0;
			restart_q  <= 1'b0;
		end else begin
			unique case (state_q)
				msc_pkg::ST_INIT: begin
					if (!rst_pin_s) begin
						state_q   <= msc_pkg::ST_HOLD;
						low_cnt_q <= RST_W'(1);
						restart_q <= 1'b1;
					end else if (init_cnt_q == INIT_LAST) begin
						state_q <= msc_pkg::ST_READY;
					end else begin
						init_cnt_q <= init_cnt_q + CNT_W'(1);
					end
				end
				msc_pkg::ST_READY: begin
					if (!rst_pin_s) begin
						state_q   <= msc_pkg::ST_HOLD;
						low_cnt_q <= RST_W'(1);
						restart_q <= 1'b0;
					end
				end
				msc_pkg::ST_HOLD: begin
					if (rst_pin_s) begin
						// Short glitches are not a reset, except during init
						state_q    <= (low_cnt_q > RST_MIN || restart_q) ?
							msc_pkg::ST_INIT : msc_pkg::ST_READY;
						init_cnt_q <= '0;
					end else if (low_cnt_q <= RST_MIN) begin
						low_cnt_q <= low_cnt_q + RST_W'(1);
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_init_busy <= 1'b1;
		end else begin
			o_init_busy <= (state_q != msc_pkg::ST_READY);
		end
	end

	// Management access, gated by select only, never by power mode
	assign taken      = i_mgmt_valid && sel_s;
	assign lower_page = (i_mgmt_req.dev == msc_pkg::DEV_ADDR_LOWER);
	assign rd_status  = taken && !i_mgmt_req.we && lower_page &&
		(i_mgmt_req.addr == msc_pkg::OFS_STATUS);
	assign rd_flag    = taken && !i_mgmt_req.we && lower_page &&
		(i_mgmt_req.addr >= msc_pkg::OFS_FLAG_FIRST) &&
		(i_mgmt_req.addr <= msc_pkg::OFS_FLAG_LAST);

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mgmt_enable <= 1'b0;
		end else begin
			o_mgmt_enable <= sel_s;
		end
	end

	always_comb begin
		rdata_d = 8'h00;
		if (lower_page) begin
			unique case (i_mgmt_req.addr)
				msc_pkg::OFS_STATUS:
					rdata_d[msc_pkg::BIT_NOT_READY] = not_ready_q;
				msc_pkg::OFS_POWER_CTRL: begin
					rdata_d[msc_pkg::BIT_PWR_OVRD] = pwr_q.override;
					rdata_d[msc_pkg::BIT_PWR_SET]  = pwr_q.set;
				end
				msc_pkg::OFS_POWER_CLASS:
					rdata_d[msc_pkg::BIT_CLASS_LSB +: 2] = POWER_CLASS;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mgmt_ack   <= 1'b0;
			o_mgmt_rdata <= 8'h00;
		end else begin
			o_mgmt_ack   <= taken;
			if (taken && !i_mgmt_req.we) begin
				o_mgmt_rdata <= rdata_d;
			end
		end
	end

	// User settings; a full reset wins over a host write
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pwr_q <= msc_pkg::PWR_CTRL_RST;
		end else if (state_q == msc_pkg::ST_HOLD && low_cnt_q > RST_MIN) begin
			pwr_q <= msc_pkg::PWR_CTRL_RST;
		end else if (taken && i_mgmt_req.we && lower_page &&
			i_mgmt_req.addr == msc_pkg::OFS_POWER_CTRL) begin
			pwr_q.override <= i_mgmt_req.wdata[msc_pkg::BIT_PWR_OVRD];
			pwr_q.set      <= i_mgmt_req.wdata[msc_pkg::BIT_PWR_SET];
		end
	end

	// Power decision and path restriction
	assign low_power_d = pwr_q.override ? pwr_q.set : lp_pin_s;
	assign restrict_d  = low_power_d && (POWER_CLASS != msc_pkg::CLASS_LOW);

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_low_power <= 1'b1;
			o_tx_enable <= 1'b0;
			o_rx_enable <= 1'b0;
		end else begin
			o_low_power <= low_power_d;
			o_tx_enable <= !restrict_d;
			o_rx_enable <= !restrict_d;
		end
	end

	// A short reset glitch must not repeat the completion interrupt
	assign seq_busy = (state_q == msc_pkg::ST_INIT) ||
		(state_q == msc_pkg::ST_HOLD && (low_cnt_q > RST_MIN || restart_q));

	// Completion interrupt, independent of the power mode
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			not_ready_q   <= 1'b1;
			o_attention_n <= 1'b1;
			armed_q       <= 1'b0;
		end else if (seq_busy) begin
			not_ready_q   <= 1'b1;
			o_attention_n <= 1'b1;
			armed_q       <= 1'b0;
		end else if (not_ready_q) begin
			not_ready_q   <= 1'b0;
			o_attention_n <= 1'b0;
		end else begin
			if (rd_status) begin
				armed_q <= 1'b1;
			end
			if (armed_q && rd_flag) begin
				o_attention_n <= 1'b1;
				armed_q       <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	sequence seq_req_taken;
		i_mgmt_valid && sel_s;
	endsequence

	sequence seq_long_low_released;
		state_q == msc_pkg::ST_HOLD && rst_pin_s && low_cnt_q > RST_MIN;
	endsequence

	sequence seq_short_low_released;
		state_q == msc_pkg::ST_HOLD && rst_pin_s && low_cnt_q <= RST_MIN &&
			!restart_q;
	endsequence

	AST_ACK_WHEN_SELECTED: assert property (
		seq_req_taken |=> o_mgmt_ack)
		else $error("selected request not acknowledged");

	AST_SILENT_DESELECTED: assert property (
		o_mgmt_ack |-> $past(i_mgmt_valid) && $past(sel_s))
		else $error("acknowledge while deselected");

	AST_POWER_DECISION: assert property (
		##1 o_low_power == ($past(pwr_q.override) ?
			$past(pwr_q.set) : $past(lp_pin_s)))
		else $error("power mode decision wrong");

	AST_RESET_DEFAULTS: assert property (
		seq_long_low_released |=> pwr_q == msc_pkg::PWR_CTRL_RST
			&& state_q == msc_pkg::ST_INIT)
		else $error("long reset did not restore defaults");

	AST_INIT_FROM_RISE: assert property (
		seq_long_low_released |=> init_cnt_q == '0 ##1 o_init_busy)
		else $error("init interval not started at release");

	AST_COMPLETE_SIGNAL: assert property (
		$fell(o_attention_n) |-> !not_ready_q &&
			state_q == msc_pkg::ST_READY)
		else $error("completion signalled with not-ready set");

	AST_RELEASE_AFTER_READS: assert property (
		$rose(o_attention_n) && state_q == msc_pkg::ST_READY
			|-> $past(armed_q) && $past(rd_flag))
		else $error("attention released without required reads");

	AST_PATH_RESTRICT: assert property (
		##1 o_tx_enable == !($past(low_power_d) &&
			POWER_CLASS != msc_pkg::CLASS_LOW))
		else $error("transmit path restriction wrong");

	AST_SYNC_DEPTH: assert property (
		##2 o_mgmt_enable == !$past(pin_s1_q[2], 2))
		else $error("select not through two stages");

	AST_SHORT_PULSE_IGNORED: assert property (
		seq_short_low_released |=> state_q == msc_pkg::ST_READY)
		else $error("short reset pulse treated as a reset");
endmodule : msc_sideband
`default_nettype wire

// ==== sim/msc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module msc_host_model (
	input  wire logic i_sys_clk,
	output logic      o_module_select_n,
	output logic      o_module_reset_n,
	output logic      o_low_power_request
);
	initial begin
		o_module_select_n   = 1'b1;
		o_module_reset_n    = 1'b1;
		o_low_power_request = 1'b1;
	end
	// Settle time also covers the two-stage pin synchroniser
	task automatic sel(input logic s);
		@(posedge i_sys_clk);
		o_module_select_n <= ~s;
		repeat (4) @(posedge i_sys_clk);
	endtask : sel
	task automatic lp(input logic v);
		@(posedge i_sys_clk);
		o_low_power_request <= v;
		repeat (5) @(posedge i_sys_clk);
	endtask : lp
	task automatic rst_pulse(input int n);
		@(posedge i_sys_clk);
		o_module_reset_n <= 1'b0;
		repeat (n) @(posedge i_sys_clk);
		o_module_reset_n <= 1'b1;
	endtask : rst_pulse
endmodule : msc_host_model
`default_nettype wire

// ==== sim/module_sideband_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module module_sideband_control_tb;
	logic              clk;
	logic              rst_n;
	logic              valid;
	msc_pkg::msc_req_s req;
	logic              sel_n, mrst_n, lpr;
	logic              en, ack, att_n, prs_n, lowp, tx, rx, busy;
	logic [7:0]        rdata;
	logic [7:0]        dev;
	logic [2:0]        bias;
	int                fail_count;
	int                checks;

	msc_host_model msc_host_model_i (
		.i_sys_clk           (clk),
		.o_module_select_n   (sel_n),
		.o_module_reset_n    (mrst_n),
		.o_low_power_request (lpr)
	);
	// Short init keeps the run brief; class 1 exercises path gating
	msc_sideband #(.INIT_CYCLES(20), .POWER_CLASS(2'h1)) msc_sideband_i (
		.i_sys_clk           (clk),
		.i_rst_n             (rst_n),
		.i_module_select_n   (sel_n),
		.i_module_reset_n    (mrst_n),
		.i_low_power_request (lpr),
		.i_mgmt_valid        (valid),
		.i_mgmt_req          (req),
		.o_mgmt_enable       (en),
		.o_mgmt_ack          (ack),
		.o_mgmt_rdata        (rdata),
		.o_pin_bias_en       (bias),
		.o_attention_n       (att_n),
		.o_presence_n        (prs_n),
		.o_low_power         (lowp),
		.o_tx_enable         (tx),
		.o_rx_enable         (rx),
		.o_init_busy         (busy)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic conclude;
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task automatic xfer(input logic we, input logic [7:0] a,
			input logic [7:0] d, output logic k, output logic [7:0] r);
		@(posedge clk);
		valid <= 1'b1;
		req   <= '{we, dev, a, d};
		@(posedge clk);
		valid <= 1'b0;
		#1;
		k = ack;
		r = rdata;
	endtask : xfer

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic       k;
		logic [7:0] r;
		xfer(1'b0, a, 8'h00, k, r);
		chk({7'h0, k}, 8'h01);
		chk(r, exp);
	endtask : rd_chk

	task automatic wait_att;
		for (int i = 0; i < 200; i++) begin
			if (att_n === 1'b0)
				return;
			@(posedge clk);
			#1;
		end
		fail_count++;
		conclude();
	endtask : wait_att

	task automatic t_powerup;
		logic       k;
		logic [7:0] r;
		chk({5'h0, bias}, 8'h07);
		chk({7'h0, prs_n}, 8'h00);
		wait_att();
		msc_host_model_i.sel(1'b1);
		// Flag read ahead of status read must not release the pin
		xfer(1'b0, msc_pkg::OFS_FLAG_FIRST, 8'h00, k, r);
		chk({7'h0, att_n}, 8'h00);
		rd_chk(msc_pkg::OFS_STATUS, 8'h00);
		xfer(1'b0, msc_pkg::OFS_FLAG_LAST, 8'h00, k, r);
		repeat (2) @(posedge clk);
		chk({7'h0, att_n}, 8'h01);
	endtask : t_powerup

	task automatic t_select;
		logic       k;
		logic [7:0] r;
		msc_host_model_i.sel(1'b0);
		chk({7'h0, en}, 8'h00);
		// Write while deselected must leave the settings alone
		xfer(1'b1, msc_pkg::OFS_POWER_CTRL, 8'h03, k, r);
		@(posedge clk);
		chk({7'h0, k | ack}, 8'h00);
		msc_host_model_i.sel(1'b1);
		chk({7'h0, en}, 8'h01);
		rd_chk(msc_pkg::OFS_POWER_CTRL, 8'h00);
		// Other device addresses are acked but change nothing
		dev = 8'ha2;
		xfer(1'b1, msc_pkg::OFS_POWER_CTRL, 8'h03, k, r);
		chk({7'h0, k}, 8'h01);
		rd_chk(msc_pkg::OFS_POWER_CLASS, 8'h00);
		dev = msc_pkg::DEV_ADDR_LOWER;
		rd_chk(msc_pkg::OFS_POWER_CTRL, 8'h00);
	endtask : t_select

	task automatic t_power;
		logic [3:0] tbl [4] = '{4'b1001, 4'b0010, 4'b0111, 4'b1100};
		logic       k;
		logic [7:0] r;
		for (int i = 0; i < 4; i++) begin
			msc_host_model_i.lp(tbl[i][3]);
			xfer(1'b1, msc_pkg::OFS_POWER_CTRL, {6'h0, tbl[i][1], tbl[i][2]},
				k, r);
			repeat (3) @(posedge clk);
			chk({7'h0, lowp}, {7'h0, tbl[i][0]});
			chk({6'h0, tx, rx}, {6'h0, {2{~tbl[i][0]}}});
			rd_chk(msc_pkg::OFS_POWER_CTRL, {6'h0, tbl[i][1], tbl[i][2]});
		end
		rd_chk(msc_pkg::OFS_POWER_CLASS, 8'h40);
	endtask : t_power

	task automatic t_reset;
		// Short pulse is ignored and keeps the override
		msc_host_model_i.rst_pulse(100);
		repeat (5) @(posedge clk);
		chk({7'h0, busy}, 8'h00);
		chk({7'h0, att_n}, 8'h01);
		rd_chk(msc_pkg::OFS_POWER_CTRL, 8'h01);
		msc_host_model_i.rst_pulse(210);
		repeat (12) @(posedge clk);
		chk({7'h0, busy}, 8'h01);
		wait_att();
		chk({7'h0, lowp}, 8'h01);
		rd_chk(msc_pkg::OFS_POWER_CTRL, 8'h00);
	endtask : t_reset

	task automatic t_por;
		logic       k;
		logic [7:0] r;
		// Power-on reset in mid-run restores defaults and completion
		xfer(1'b1, msc_pkg::OFS_POWER_CTRL, 8'h01, k, r);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk({ack, en, att_n, busy, lowp, tx, rx, prs_n}, 8'h38);
		rst_n <= 1'b1;
		wait_att();
		rd_chk(msc_pkg::OFS_POWER_CTRL, 8'h00);
	endtask : t_por

	initial begin
		fail_count = 0;
		checks     = 0;
		rst_n      = 1'b0;
		valid      = 1'b0;
		req        = '0;
		dev        = msc_pkg::DEV_ADDR_LOWER;
		repeat (12) @(posedge clk);
		chk({6'h0, att_n, busy}, 8'h03);
		rst_n <= 1'b1;
		t_powerup();
		t_select();
		t_power();
		t_reset();
		t_por();
		conclude();
	end
endmodule : module_sideband_control_tb
`default_nettype wire
